//--- cpu_interrupt_sequencer_regs.vh
// Register offsets, field layouts, reset values and sequence constants.
`ifndef CPU_INTERRUPT_SEQUENCER_REGS_VH
`define CPU_INTERRUPT_SEQUENCER_REGS_VH

// Register offsets on the 8-bit register port.
`define ADDR_EXT_SENSE    8'h00
`define ADDR_PERIPH_EN    8'h01
`define ADDR_EXT_STATUS   8'h02
`define ADDR_PERIPH_STAT  8'h03

// Reset values.
`define EXT_SENSE_RST     8'h00
`define PERIPH_EN_RST     6'h00
`define SP_RST            8'h7f

// Sensitivity codes of one external line.
`define SENSE_FALL_LOW    2'b00
`define SENSE_RISE        2'b01
`define SENSE_FALL        2'b10
`define SENSE_BOTH        2'b11

// Bit of the external status register that mirrors the global mask.
`define EXT_STATUS_MASK_BIT 7

// Vector slots: external lines and peripherals.
`define SLOT_EXT_FIRST    4'd1
`define SLOT_PER_FIRST    4'd7
`define SLOT_LAST         4'd12

// Vector addresses (address of the high byte of each pair).
`define VEC_RESET         16'hfffe
`define VEC_TRAP          16'hfffc
`define VEC_SLOT0         16'hfffa

// Peripheral sources able to leave halt: overflow, tick, serial.
`define PER_HALT_WAKE     6'h34

// Locations that one saved context takes on the stack.
`define CTX_BYTES         3'd5

`endif

//--- cpu_interrupt_sequencer.v
// Interrupt sequencer: requests, priority, context save and vectoring.
`timescale 1ns/1ps
`include "cpu_interrupt_sequencer_regs.vh"

module cpu_interrupt_sequencer (
    // Clock and reset.
    input  wire        clk_sys_i,
    input  wire        rst_n_i,
    // Register port.
    input  wire [7:0]  addr_i,
    input  wire [7:0]  wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [7:0]  rdata_o,
    // Core control.
    input  wire        boundary_i,
    input  wire        trap_i,
    input  wire        return_from_isr_i,
    input  wire        mask_set_i,
    input  wire        mask_clr_i,
    input  wire        wait_i,
    input  wire        halt_i,
    // Core context to save.
    input  wire [15:0] core_pc_i,
    input  wire [7:0]  core_x_i,
    input  wire [7:0]  core_a_i,
    input  wire [7:0]  condition_code_reg_i,
    // External lines and combined-pin low indication.
    input  wire [3:0]  ext_irq_line_i,
    input  wire [3:0]  ext_block_i,
    // Peripheral flags and their clear-sequence strobes.
    input  wire [5:0]  periph_flag_i,
    input  wire [5:0]  periph_clr_i,
    // Stack access.
    output reg         stack_we_o,
    output reg         stack_re_o,
    output reg  [7:0]  stack_addr_o,
    output reg  [7:0]  stack_wdata_o,
    output reg  [2:0]  stack_sel_o,
    // Sequencing results.
    output reg  [15:0] vector_o,
    output reg         vector_load_o,
    output reg         resume_o,
    output reg         global_mask_o,
    output wire        busy_o,
    output wire        wake_o
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations.

    // Sequencer states.
    localparam [2:0] ST_RESET = 3'd0;
    localparam [2:0] ST_IDLE  = 3'd1;
    localparam [2:0] ST_PUSH  = 3'd2;
    localparam [2:0] ST_VEC   = 3'd3;
    localparam [2:0] ST_POP   = 3'd4;

    reg  [2:0]  state_q;        // Current sequencer state.
    reg  [2:0]  step_q;         // Byte counter inside push or pop.
    reg  [7:0]  sp_q;           // Stack pointer.
    reg         trap_sel_q;     // Entry being served is the trap.
    reg  [3:0]  slot_q;         // Slot being served.
    reg  [7:0]  ext_sense_q;    // Two bits of sensitivity per line.
    reg  [5:0]  periph_en_q;    // Peripheral enables.
    reg  [3:0]  ext_prev_q;     // Last sampled line levels.
    reg  [5:0]  flag_prev_q;    // Last sampled peripheral flags.
    reg  [3:0]  ext_pend_q;     // Latched external edges.
    reg  [5:0]  per_pend_q;     // Latched peripheral events.

    wire [3:0]  ext_req;        // External requests before the mask.
    wire [5:0]  per_req;        // Peripheral requests before the mask.
    wire [3:0]  ext_clr;        // Per-line clear of the edge latch.
    wire [5:0]  per_clr;        // Per-source clear of the latch.
    wire [12:0] slot_req;       // Requests by vector slot.
    wire        sense_wr;       // Accepted write of the sense register.
    wire        entry_done;     // Vector of a maskable source, not the trap, is being loaded this cycle.
    reg  [3:0]  win_slot;       // Winning slot of this cycle.
    reg         win_any;        // Some unmasked request exists.
    integer     k;

    assign sense_wr   = wr_i & (addr_i == `ADDR_EXT_SENSE) & global_mask_o;
    assign entry_done = (state_q == ST_VEC) & ~trap_sel_q;
    assign busy_o     = (state_q != ST_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // External lines.

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_ext
            wire [1:0] mode;
            wire       fall;
            wire       rise;
            wire       hit;
            assign mode = ext_sense_q[2*g+1:2*g];
            assign fall = ext_prev_q[g] & ~ext_irq_line_i[g];
            assign rise = ~ext_prev_q[g] & ext_irq_line_i[g];
            // Edge selection by the sensitivity code.
            assign hit  = (mode == `SENSE_RISE) ? rise :
                          (mode == `SENSE_BOTH) ? (rise | fall) : fall;
            // Entry of this line or a sense change empties its latch.
            assign ext_clr[g] = (entry_done & (slot_q ==
                                 `SLOT_EXT_FIRST + g)) |
                                (sense_wr & (wdata_i[2*g+1:2*g]
                                 != mode));
            // A low on a combined pin masks the request outright.
            assign ext_req[g] = ~ext_block_i[g] &
                                (ext_pend_q[g] |
                                 ((mode == `SENSE_FALL_LOW) &
                                  ~ext_irq_line_i[g]));
            // New edges are latched; an edge in the clearing cycle wins.
            always @(posedge clk_sys_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    ext_pend_q[g] <= 1'b0;
                end else if (hit) begin
                    ext_pend_q[g] <= 1'b1;
                end else if (ext_clr[g]) begin
                    ext_pend_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Peripheral sources.

    generate
        for (g = 0; g < 6; g = g + 1) begin : g_per
            // Clear sequence or entry of this source empties the latch.
            assign per_clr[g] = periph_clr_i[g] |
                                (entry_done &
                                 (slot_q == `SLOT_PER_FIRST + g));
            // Only an enabled latched event asks for service.
            assign per_req[g] = per_pend_q[g] & periph_en_q[g];
            // The latch holds a disabled event as pending.
            always @(posedge clk_sys_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    per_pend_q[g] <= 1'b0;
                end else if (periph_flag_i[g] & ~flag_prev_q[g]) begin
                    per_pend_q[g] <= 1'b1;
                end else if (per_clr[g]) begin
                    per_pend_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // Slot map: 1..4 external, 7..12 peripherals, others unused.
    assign slot_req = {per_req, 2'b00, ext_req, 1'b0};

    ////////////////////////////////////////////////////////////////////////
    // Wake-up from the low-power states.

    // Wait is left by any request; halt only by capable ones. Non-capable
    // peripherals stay latched and are served after some other wake-up.
    assign wake_o = (wait_i & (|slot_req)) |
                    (halt_i & ((|ext_req) |
                     (|(per_req & `PER_HALT_WAKE))));

    ////////////////////////////////////////////////////////////////////////
    // Arbitration: the lowest slot number wins.

    // Scanning downward lets lower slots overwrite higher ones, so the
    // whole choice settles in one combinational pass.
    always @* begin
        win_slot = 4'd0;
        win_any  = 1'b0;
        for (k = 12; k >= 1; k = k - 1) begin
            if (slot_req[k] & ~global_mask_o) begin
                win_slot = k[3:0];
                win_any  = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers written by software and sampled inputs.

    // The sense register ignores writes while the mask is clear, so a
    // running program cannot alter edge detection under its feet.
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ext_sense_q <= `EXT_SENSE_RST;
            periph_en_q <= `PERIPH_EN_RST;
            ext_prev_q  <= 4'hf;
            flag_prev_q <= 6'h00;
        end else begin
            ext_prev_q  <= ext_irq_line_i;
            flag_prev_q <= periph_flag_i;
            if (sense_wr) begin
                ext_sense_q <= wdata_i;
            end
            if (wr_i & (addr_i == `ADDR_PERIPH_EN)) begin
                periph_en_q <= wdata_i[5:0];
            end
        end
    end

    // Read data stand in the cycle after the strobe only.
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                `ADDR_EXT_SENSE:   rdata_o <= ext_sense_q;
                `ADDR_PERIPH_EN:   rdata_o <= {2'b00, periph_en_q};
                `ADDR_EXT_STATUS:  rdata_o <= {global_mask_o, 3'b000,
                                               ext_pend_q};
                `ADDR_PERIPH_STAT: rdata_o <= {2'b00, per_pend_q};
                default:           rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Entry and return sequencer.

    // One process owns the stack port, the mask bit and the vector so
    // that no two actions can fight over the stack pointer.
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q       <= ST_RESET;
            step_q        <= 3'd0;
            sp_q          <= `SP_RST;
            trap_sel_q    <= 1'b0;
            slot_q        <= 4'd0;
            global_mask_o <= 1'b1;
            stack_we_o    <= 1'b0;
            stack_re_o    <= 1'b0;
            stack_addr_o  <= 8'h00;
            stack_wdata_o <= 8'h00;
            stack_sel_o   <= 3'd0;
            vector_o      <= 16'h0000;
            vector_load_o <= 1'b0;
            resume_o      <= 1'b0;
        end else begin
            stack_we_o    <= 1'b0;
            stack_re_o    <= 1'b0;
            vector_load_o <= 1'b0;
            resume_o      <= 1'b0;
            case (state_q)
                // Reset outranks every source: fetch its vector first.
                ST_RESET: begin
                    vector_o      <= `VEC_RESET;
                    vector_load_o <= 1'b1;
                    state_q       <= ST_IDLE;
                end
                // Mask changes act at once; entry or return starts only on a finished instruction.
                ST_IDLE: begin
                    if (mask_set_i) begin
                        global_mask_o <= 1'b1;
                    end else if (mask_clr_i) begin
                        global_mask_o <= 1'b0;
                    end
                    if (boundary_i) begin
                        step_q <= 3'd0;
                        if (return_from_isr_i) begin
                            state_q <= ST_POP;
                        end else if (trap_i) begin
                            trap_sel_q <= 1'b1;
                            state_q    <= ST_PUSH;
                        end else if (win_any) begin
                            trap_sel_q <= 1'b0;
                            slot_q     <= win_slot;
                            state_q    <= ST_PUSH;
                        end
                    end
                end
                // Save PCL, PCH, X, A, CC, one byte a cycle downward.
                ST_PUSH: begin
                    stack_we_o   <= 1'b1;
                    stack_addr_o <= sp_q;
                    stack_sel_o  <= step_q;
                    sp_q         <= sp_q - 8'h01;
                    case (step_q)
                        3'd0:    stack_wdata_o <= core_pc_i[7:0];
                        3'd1:    stack_wdata_o <= core_pc_i[15:8];
                        3'd2:    stack_wdata_o <= core_x_i;
                        3'd3:    stack_wdata_o <= core_a_i;
                        default: stack_wdata_o <= condition_code_reg_i;
                    endcase
                    if (step_q == `CTX_BYTES - 3'd1) begin
                        state_q <= ST_VEC;
                    end else begin
                        step_q <= step_q + 3'd1;
                    end
                end
                // Mask further requests and hand the vector to the core.
                ST_VEC: begin
                    global_mask_o <= 1'b1;
                    vector_load_o <= 1'b1;
                    if (trap_sel_q) begin
                        vector_o <= `VEC_TRAP;
                    end else begin
                        // Each slot sits one pair below the one before.
                        vector_o <= `VEC_SLOT0 -
                                    {11'h000, slot_q, 1'b0};
                    end
                    state_q <= ST_IDLE;
                end
                // Read the five bytes back upward, then unmask.
                ST_POP: begin
                    stack_re_o   <= 1'b1;
                    stack_addr_o <= sp_q + 8'h01;
                    stack_sel_o  <= `CTX_BYTES - 3'd1 - step_q;
                    sp_q         <= sp_q + 8'h01;
                    if (step_q == `CTX_BYTES - 3'd1) begin
                        global_mask_o <= 1'b0;
                        resume_o      <= 1'b1;
                        state_q       <= ST_IDLE;
                    end else begin
                        step_q <= step_q + 3'd1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // cpu_interrupt_sequencer

//--- cpu_interrupt_sequencer_asserts.sv
// Port checks for the interrupt sequencer.
`timescale 1ns/1ps
module cpu_interrupt_sequencer_asserts (
    // Clock, reset, core requests, register read port and stack address.
    input wire logic        clk_sys_i, rst_n_i, rd_i, boundary_i,
    input wire logic        trap_i, return_from_isr_i,
    input wire logic [7:0]  addr_i, rdata_o, stack_addr_o,
    // Sequencing outputs.
    input wire logic        stack_we_o, stack_re_o, vector_load_o,
    input wire logic        resume_o, global_mask_o, busy_o,
    input wire logic [2:0]  stack_sel_o,
    input wire logic [15:0] vector_o
);
default clocking cb @(posedge clk_sys_i); endclocking
default disable iff (!rst_n_i);
////////////////////////////////////////////////////////////////////////
// Push of PCH, X, A, CC after PCL, then the vector with the mask set.
sequence s_push_tail;
    stack_we_o && stack_sel_o == 3'd1 ##1 stack_we_o && stack_sel_o == 3'd2
    ##1 stack_we_o && stack_sel_o == 3'd3
    ##1 stack_we_o && stack_sel_o == 3'd4 ##1 vector_load_o && global_mask_o;
endsequence
// Pops start with CC and end with PCL beside the resume pulse.
sequence s_pop_all;
    stack_re_o && stack_sel_o == 3'd4 ##1 stack_re_o && stack_sel_o == 3'd3
    ##1 stack_re_o && stack_sel_o == 3'd2
    ##1 stack_re_o && stack_sel_o == 3'd1
    ##1 stack_re_o && stack_sel_o == 3'd0 && resume_o && !global_mask_o;
endsequence
a_entry_push: assert property (stack_we_o && stack_sel_o == 3'd0
    |=> s_push_tail) else $error("entry push order wrong");
a_return_pop: assert property (!busy_o && boundary_i && return_from_isr_i
    |=> ##1 s_pop_all) else $error("return pop order wrong");
a_trap_vector: assert property (!busy_o && boundary_i && trap_i
    && !return_from_isr_i |-> ##7 vector_load_o && vector_o == 16'hfffc)
    else $error("trap vector wrong");
a_reset_vector: assert property ($rose(rst_n_i) |=> vector_load_o
    && vector_o == 16'hfffe && global_mask_o) else $error("reset vector");
a_mask_gate: assert property (vector_load_o && vector_o != 16'hfffc
    && vector_o != 16'hfffe |-> $past(global_mask_o, 7) == 1'b0)
    else $error("maskable taken while masked");
a_busy_span: assert property (stack_we_o && stack_sel_o == 3'd0
    |-> busy_o [*5] ##1 !busy_o) else $error("busy span wrong");
a_push_addr: assert property (stack_we_o && stack_sel_o != 3'd0
    |-> stack_addr_o == $past(stack_addr_o) - 8'd1)
    else $error("push address not descending");
a_pop_addr: assert property (stack_re_o && stack_sel_o != 3'd4
    |-> stack_addr_o == $past(stack_addr_o) + 8'd1)
    else $error("pop address not ascending");
a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside read cycle");
a_status_mask: assert property ($past(rd_i) && $past(addr_i) == 8'h02
    |-> rdata_o[7] == $past(global_mask_o)) else $error("mask mirror");
endmodule // cpu_interrupt_sequencer_asserts
bind cpu_interrupt_sequencer cpu_interrupt_sequencer_asserts i_chk (
    .clk_sys_i, .rst_n_i, .rd_i, .boundary_i, .trap_i, .return_from_isr_i,
    .addr_i, .rdata_o, .stack_addr_o, .stack_we_o, .stack_re_o,
    .vector_load_o, .resume_o, .global_mask_o, .busy_o, .stack_sel_o,
    .vector_o);

//--- stack_ram_model.sv
// Core-side stack memory that keeps every pushed context byte.
`timescale 1ns/1ps
module stack_ram_model (
    // Clock and push port.
    input  wire logic       clk_sys_i,
    input  wire logic       we_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    // Inspection port for the bench.
    input  wire logic [7:0] peek_addr_i,
    output logic      [7:0] peek_data_o
);
    logic [7:0] mem [256]; // Whole page, so a wrong address is seen.
    // Store each pushed byte where the sequencer points.
    always @(posedge clk_sys_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
    end
    assign peek_data_o = mem[peek_addr_i];
endmodule // stack_ram_model

//--- test_cpu_interrupt_sequencer.sv
// Self-checking bench for the interrupt sequencer.
`timescale 1ns/1ps
module test_cpu_interrupt_sequencer;
    logic clk_sys_i, rst_n_i, wr_i, rd_i, boundary_i, trap_i;
    logic return_from_isr_i, mask_set_i, mask_clr_i, wait_i, halt_i;
    logic [7:0] addr_i, wdata_i, core_x_i, core_a_i, condition_code_reg_i;
    logic [15:0] core_pc_i;
    logic [3:0] ext_irq_line_i, ext_block_i;
    logic [5:0] periph_flag_i, periph_clr_i;
    wire [7:0] rdata_o, stack_addr_o, stack_wdata_o, peek_data;
    wire [2:0] stack_sel_o;
    wire [15:0] vector_o;
    wire stack_we_o, stack_re_o, vector_load_o, resume_o;
    wire global_mask_o, busy_o, wake_o;
    logic [7:0] peek_addr;
    int miscompares, n_tests, cycles, k;
    logic [7:0] ctx [5] = '{8'h34, 8'h12, 8'h56, 8'h78, 8'h9a};
    logic [15:0] vt [10] = '{16'hfff8, 16'hfff6, 16'hfff4, 16'hfff2,
        16'hffec, 16'hffea, 16'hffe8, 16'hffe6, 16'hffe4, 16'hffe2};
    cpu_interrupt_sequencer i_cpu_interrupt_sequencer (.clk_sys_i, .rst_n_i,
        .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .boundary_i, .trap_i,
        .return_from_isr_i, .mask_set_i, .mask_clr_i, .wait_i, .halt_i,
        .core_pc_i, .core_x_i, .core_a_i, .condition_code_reg_i,
        .ext_irq_line_i, .ext_block_i, .periph_flag_i, .periph_clr_i,
        .stack_we_o, .stack_re_o, .stack_addr_o, .stack_wdata_o,
        .stack_sel_o, .vector_o, .vector_load_o, .resume_o, .global_mask_o,
        .busy_o, .wake_o);
    stack_ram_model i_stack_ram_model (.clk_sys_i, .we_i(stack_we_o),
        .addr_i(stack_addr_o), .wdata_i(stack_wdata_o),
        .peek_addr_i(peek_addr), .peek_data_o(peek_data));
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    ////////////////////////////////////////////////////////////////////
    // Shared helpers: compare, wait, register cycles, core boundary.
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1;
        chk("rdata", {8'h00, e}, {8'h00, rdata_o});
    endtask
    task mask(input logic s);
        @(posedge clk_sys_i);
        mask_set_i <= s;
        mask_clr_i <= ~s;
        @(posedge clk_sys_i);
        mask_set_i <= 1'b0;
        mask_clr_i <= 1'b0;
    endtask
    // Falling edge on the chosen lines, which idle high.
    task ext_fall(input logic [3:0] m);
        @(posedge clk_sys_i);
        ext_irq_line_i <= ~m;
        cyc(2);
        ext_irq_line_i <= 4'hf;
        cyc(2);
    endtask
    // One finished instruction; a zero vector means nothing is taken.
    task go(input logic t, input logic r, input logic [15:0] e);
        logic [15:0] got;
        got = 16'h0000;
        @(posedge clk_sys_i);
        boundary_i <= 1'b1;
        trap_i <= t;
        return_from_isr_i <= r;
        @(posedge clk_sys_i);
        boundary_i <= 1'b0;
        trap_i <= 1'b0;
        return_from_isr_i <= 1'b0;
        repeat (10) begin
            #1;
            if (vector_load_o === 1'b1) got = vector_o;
            @(posedge clk_sys_i);
        end
        chk("vector", e, got);
    endtask
    ////////////////////////////////////////////////////////////////////
    // Scenarios.
    task t_reset;
        rd(8'h02, 8'h80);
        rd(8'h03, 8'h00);
        rd(8'h10, 8'h00);
    endtask
    // Trap while masked, context on the stack, then return.
    task t_trap;
        go(1'b1, 1'b0, 16'hfffc);
        for (k = 0; k < 5; k++) begin
            peek_addr = 8'h7f - k[7:0];
            #1;
            chk("stack", {8'h00, ctx[k]}, {8'h00, peek_data});
        end
        go(1'b0, 1'b1, 16'h0000);
        chk("mask", 16'h0000, {15'h0000, global_mask_o});
    endtask
    // All sources pending at once are served in table order.
    task t_priority;
        mask(1'b1);
        wr(8'h00, 8'haa);
        wr(8'h01, 8'h3f);
        ext_fall(4'hf);
        periph_flag_i <= 6'h3f;
        rd(8'h02, 8'h8f);
        rd(8'h03, 8'h3f);
        go(1'b0, 1'b0, 16'h0000);
        mask(1'b0);
        for (k = 0; k < 10; k++) begin
            go(1'b0, 1'b0, vt[k]);
            go(1'b0, 1'b1, 16'h0000);
        end
        rd(8'h02, 8'h00);
        rd(8'h03, 8'h00);
        periph_flag_i <= 6'h00;
    endtask
    // Clear sequence discards a pending request; disabled stays pending.
    task t_clear;
        mask(1'b1);
        periph_flag_i <= 6'h01;
        rd(8'h03, 8'h01);
        periph_clr_i <= 6'h01;
        @(posedge clk_sys_i);
        periph_clr_i <= 6'h00;
        rd(8'h03, 8'h00);
        mask(1'b0);
        go(1'b0, 1'b0, 16'h0000);
        periph_flag_i <= 6'h00;
        wr(8'h01, 8'h3d);
        periph_flag_i <= 6'h02;
        go(1'b0, 1'b0, 16'h0000);
        rd(8'h03, 8'h02);
        periph_clr_i <= 6'h02;
        @(posedge clk_sys_i);
        periph_clr_i <= 6'h00;
        periph_flag_i <= 6'h00;
        wr(8'h01, 8'h3f);
    endtask
    // Sense writes need the mask; a code change drops the latch.
    task t_sense;
        wr(8'h00, 8'h55);
        rd(8'h00, 8'haa);
        mask(1'b1);
        ext_fall(4'h1);
        rd(8'h02, 8'h81);
        wr(8'h00, 8'hab);
        rd(8'h02, 8'h80);
        ext_block_i <= 4'h2;
        ext_fall(4'h2);
        mask(1'b0);
        go(1'b0, 1'b0, 16'h0000);
        mask(1'b1);
        wr(8'h00, 8'h00);
        wr(8'h00, 8'haa);
        ext_block_i <= 4'h0;
        // Line 0 on rising edges only: the fall is ignored, the rise kept.
        wr(8'h00, 8'h01);
        ext_irq_line_i <= 4'he;
        rd(8'h02, 8'h80);
        ext_irq_line_i <= 4'hf;
        rd(8'h02, 8'h81);
        mask(1'b0);
        go(1'b0, 1'b0, 16'hfff8);
        go(1'b0, 1'b1, 16'h0000);
        mask(1'b1);
        wr(8'h00, 8'haa);
    endtask
    // Wake from wait by any source, from halt by capable ones only.
    task t_wake;
        wait_i <= 1'b1;
        periph_flag_i <= 6'h08;
        cyc(3);
        chk("wake", 16'h0001, {15'h0000, wake_o});
        wait_i <= 1'b0;
        halt_i <= 1'b1;
        cyc(2);
        chk("wake", 16'h0000, {15'h0000, wake_o});
        periph_flag_i <= 6'h0c;
        cyc(3);
        chk("wake", 16'h0001, {15'h0000, wake_o});
        halt_i <= 1'b0;
        periph_clr_i <= 6'h0c;
        @(posedge clk_sys_i);
        periph_clr_i <= 6'h00;
    endtask
    task complete_run;
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // A hang counts as a mismatch and ends the run.
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            complete_run();
        end
    end
    initial begin
        {rst_n_i, wr_i, rd_i, boundary_i, trap_i, return_from_isr_i} = '0;
        {mask_set_i, mask_clr_i, wait_i, halt_i, addr_i, wdata_i} = '0;
        {ext_block_i, periph_flag_i, periph_clr_i, peek_addr} = '0;
        {miscompares, n_tests, cycles} = '0;
        ext_irq_line_i = 4'hf;
        core_pc_i = 16'h1234;
        core_x_i = 8'h56;
        core_a_i = 8'h78;
        condition_code_reg_i = 8'h9a;
        repeat (6) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        cyc(2);
        t_reset();
        t_trap();
        t_priority();
        t_clear();
        t_sense();
        t_wake();
        complete_run();
    end
endmodule // test_cpu_interrupt_sequencer
